//--- sim/ecp_periph_model.sv
// peripheral side model of the extended parallel port link
`timescale 1ns/1ns
module ecp_periph_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // device pins
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic strobe_n,
  input wire logic tag,
  input wire logic init_n,
  output logic [7:0] data_in,
  output logic valid_n,
  output logic busy,
  output logic rev_ack_n,
  output logic err_n,
  // bench control
  input wire logic stall,
  input wire logic err_req
);
  logic [8:0] rx_q[$];
  logic [8:0] tx_q[$];
  logic [7:0] drv_data;
  logic [7:0] last_data = 8'h00;
  logic drv_en = 1'b0;
  logic strobe_q;
  logic [1:0] rs;
  // a released bus toggles so a stale byte never looks valid
  assign data_in = data_oe ? data_out : (drv_en ? drv_data : ~last_data);
  always @(posedge sys_clk) begin
    last_data <= data_in;
    strobe_q <= strobe_n;
    err_n <= !err_req;
    rev_ack_n <= init_n;
    if (!nrst) begin
      busy <= 1'b0;
      valid_n <= 1'b1;
      drv_en <= 1'b0;
      rs <= 2'h0;
    end else if (rev_ack_n) begin
      // byte taken once the strobe has been low for a full cycle
      if (!busy && !strobe_n && !strobe_q) begin
        rx_q.push_back({tag, data_in});
        busy <= 1'b1;
      end else if (busy && strobe_n && !stall) begin
        busy <= 1'b0;
      end
    end else begin
      case (rs)
        2'h0: if (!tag && tx_q.size() > 0) begin
          drv_data <= tx_q[0][7:0];
          busy <= !tx_q[0][8];
          drv_en <= 1'b1;
          rs <= 2'h1;
        end
        2'h1: begin
          valid_n <= 1'b0;
          rs <= 2'h2;
        end
        2'h2: if (tag) begin
          valid_n <= 1'b1;
          void'(tx_q.pop_front());
          rs <= 2'h3;
        end
        default: begin
          drv_en <= 1'b0;
          rs <= 2'h0;
        end
      endcase
    end
  end
endmodule

//--- sim/testbench.sv
// self-checking bench for the extended parallel port block
`timescale 1ns/1ns
module testbench import ecp_pkg::*; ();
  logic sys_clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hF;
  logic dma_ack = 1'b0, dma_tc = 1'b0, stall = 1'b0, err_req = 1'b0;
  logic [7:0] dma_wdata = 8'h00;
  logic [31:0] readdata;
  logic [7:0] dma_rdata, pd_out, pd_in, rd;
  logic waitrequest, port_dma_request, port_irq, pd_oe, stb_n, tag, init_n, sel_n;
  logic valid_n, busy, rev_ack_n, err_n;
  logic [8:0] exp_q[$];
  int failures = 0;
  int n_checks = 0;

  always #4 sys_clk = ~sys_clk;

  ecp_port ecp_port_i (.sys_clk(sys_clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .port_dma_request(port_dma_request), .dma_ack(dma_ack),
    .dma_tc(dma_tc), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .port_irq(port_irq),
    .port_data_lines_in(pd_in), .port_data_lines_out(pd_out), .port_data_lines_oe(pd_oe),
    .host_write_pulse_n(stb_n), .host_tag_line(tag), .initialise_out_n(init_n),
    .select_input_out_n(sel_n), .peripheral_valid_line_n(valid_n),
    .peripheral_handshake_line(busy), .turnaround_acknowledge_n(rev_ack_n),
    .peripheral_error_line_n(err_n), .printer_select(1'b1));

  ecp_periph_model ecp_periph_model_i (.sys_clk(sys_clk), .nrst(nrst), .data_out(pd_out),
    .data_oe(pd_oe), .strobe_n(stb_n), .tag(tag), .init_n(init_n), .data_in(pd_in),
    .valid_n(valid_n), .busy(busy), .rev_ack_n(rev_ack_n), .err_n(err_n), .stall(stall),
    .err_req(err_req));

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one avalon access; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    address <= a;
    writedata <= {24'h000000, d};
    write <= wr;
    read <= !wr;
    do begin
      @(posedge sys_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask

  function automatic logic [7:0] ecr(input logic [2:0] m, input logic dma, input logic svc);
    return {m, 1'b0, dma, svc, 2'b00};
  endfunction

  // waits for the peripheral to see every expected byte, then compares in order
  task automatic drain();
    int n;
    logic [8:0] got, want;
    n = 0;
    while (ecp_periph_model_i.rx_q.size() < exp_q.size() && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    cyc(20);
    chk_byte(8'(ecp_periph_model_i.rx_q.size()), 8'(exp_q.size()), "count");
    while (exp_q.size() > 0 && ecp_periph_model_i.rx_q.size() > 0) begin
      got = ecp_periph_model_i.rx_q.pop_front();
      want = exp_q.pop_front();
      chk_byte(got[7:0], want[7:0], "fwd byte");
      chk_bit(got[8], want[8], "fwd tag");
    end
    exp_q.delete();
    ecp_periph_model_i.rx_q.delete();
  endtask

  initial begin
    #400000;
    failures++;
    end_of_test();
  end

  initial begin
    logic [7:0] b;
    logic c;
    int n;
    void'($urandom(59));
    cyc(4);
    nrst <= 1'b1;
    bus(1'b0, OFF_ECR, 8'h00);
    chk_byte(rd & 8'hEF, {MODE_RST, 2'b00, SVC_RST, 2'b01}, "ecr reset");
    bus(1'b0, OFF_THR, 8'h00);
    chk_byte(rd, {4'h0, THR_RST}, "thr reset");
    bus(1'b0, OFF_CTRL, 8'h00);
    chk_byte(rd, CTRL_RO_ONES | CTRL_RST, "ctrl reset");
    bus(1'b0, 5'h18, 8'h00);
    chk_byte(rd, 8'h00, "unmapped");
    // from ecp only the software modes are reachable
    bus(1'b1, OFF_ECR, ecr(MODE_ECP, 1'b0, 1'b1));
    bus(1'b1, OFF_ECR, ecr(MODE_PFIFO, 1'b0, 1'b1));
    bus(1'b0, OFF_ECR, 8'h00);
    chk_byte({5'h00, rd[7:5]}, {5'h00, MODE_ECP}, "mode locked");
    bus(1'b1, OFF_CTRL, 8'h20);
    bus(1'b0, OFF_CTRL, 8'h00);
    chk_byte(rd, CTRL_RO_ONES, "dir locked");
    chk_bit(sel_n, 1'b1, "select in ecp");
    // stalled peripheral: fill until full, one more is dropped
    stall <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      b = 8'($urandom());
      c = (i % 4 == 3);
      bus(1'b1, c ? OFF_DATA : OFF_DFIFO, b);
      exp_q.push_back({!c, b});
      if (i == 0) cyc(12);
    end
    bus(1'b0, OFF_ECR, 8'h00);
    chk_bit(rd[1], 1'b1, "full");
    chk_bit(rd[0], 1'b0, "not empty");
    bus(1'b1, OFF_DFIFO, 8'hEE);
    stall <= 1'b0;
    drain();
    bus(1'b0, OFF_ECR, 8'h00);
    chk_bit(rd[0], 1'b1, "empty");
    chk_bit(port_irq, 1'b0, "irq idle");
    err_req <= 1'b1;
    cyc(8);
    chk_bit(port_irq, 1'b1, "error event");
    bus(1'b0, OFF_STATUS, 8'h00);
    chk_byte(rd, 8'hF7, "status pins");
    err_req <= 1'b0;
    bus(1'b1, OFF_ECR, ecr(MODE_ECP, 1'b0, 1'b1));
    cyc(2);
    chk_bit(port_irq, 1'b0, "irq cleared");
    // programmed transfer: empty fifo has enough free slots
    bus(1'b1, OFF_ECR, ecr(MODE_ECP, 1'b0, 1'b0));
    cyc(4);
    chk_bit(port_irq, 1'b1, "free space event");
    bus(1'b0, OFF_ECR, 8'h00);
    chk_bit(rd[2], 1'b1, "svc set");
    bus(1'b1, OFF_ECR, ecr(MODE_ECP, 1'b0, 1'b1));
    cyc(4);
    chk_bit(port_irq, 1'b0, "svc write quiet");
    chk_bit(port_dma_request, 1'b0, "dma off");
    bus(1'b1, OFF_ECR, ecr(MODE_ECP, 1'b1, 1'b0));
    cyc(2);
    chk_bit(port_dma_request, 1'b1, "dma request");
    n = 3 + ($urandom() % 4);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom());
      dma_ack <= 1'b1;
      dma_wdata <= b;
      dma_tc <= (i == n - 1);
      exp_q.push_back({1'b1, b});
      @(posedge sys_clk);
      dma_ack <= 1'b0;
      dma_tc <= 1'b0;
      @(posedge sys_clk);
    end
    cyc(2);
    chk_bit(port_dma_request, 1'b0, "dma stop at tc");
    chk_bit(port_irq, 1'b1, "tc event");
    bus(1'b0, OFF_ECR, 8'h00);
    chk_bit(rd[2], 1'b1, "svc at tc");
    drain();
    // reverse: direction only settable in bidirectional mode
    bus(1'b1, OFF_ECR, ecr(MODE_BIDIR, 1'b0, 1'b1));
    bus(1'b1, OFF_CTRL, 8'h20);
    bus(1'b0, OFF_CTRL, 8'h00);
    chk_byte(rd, 8'hE0, "dir in bidir");
    bus(1'b1, OFF_ECR, ecr(MODE_ECP, 1'b0, 1'b1));
    for (int i = 0; i < 5; i++) begin
      b = 8'($urandom()) | ((i == 1) ? 8'h80 : 8'h00);
      c = (i == 1 || i == 3);
      ecp_periph_model_i.tx_q.push_back({c, b});
      exp_q.push_back({c, c ? {1'b0, b[6:0]} : b});
    end
    cyc(6);
    chk_bit(init_n, 1'b0, "reverse request");
    n = 0;
    while (ecp_periph_model_i.tx_q.size() > 0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    cyc(10);
    chk_bit(pd_oe, 1'b0, "bus released");
    // five valid bytes: below the reset threshold, then above a lowered one
    bus(1'b1, OFF_ECR, ecr(MODE_ECP, 1'b0, 1'b0));
    cyc(3);
    chk_bit(port_irq, 1'b0, "fill below threshold");
    bus(1'b1, OFF_THR, 8'h04);
    cyc(3);
    chk_bit(port_irq, 1'b1, "fill level event");
    bus(1'b1, OFF_ECR, ecr(MODE_ECP, 1'b1, 1'b0));
    dma_ack <= 1'b1;
    @(posedge sys_clk);
    dma_ack <= 1'b0;
    @(posedge sys_clk);
    chk_byte(dma_rdata, exp_q[0][7:0], "dma rev byte");
    void'(exp_q.pop_front());
    bus(1'b1, OFF_ECR, ecr(MODE_ECP, 1'b0, 1'b1));
    while (exp_q.size() > 0) begin
      bus(1'b0, OFF_DFIFO, 8'h00);
      chk_byte(rd, exp_q[0][7:0], "rev byte");
      void'(exp_q.pop_front());
    end
    bus(1'b0, OFF_ECR, 8'h00);
    chk_bit(rd[0], 1'b1, "rev empty");
    // test mode loops a byte through the shared buffer
    bus(1'b1, OFF_ECR, ecr(MODE_BIDIR, 1'b0, 1'b1));
    bus(1'b1, OFF_ECR, ecr(MODE_TEST, 1'b0, 1'b1));
    b = 8'($urandom());
    bus(1'b1, OFF_DFIFO, b);
    bus(1'b0, OFF_DFIFO, 8'h00);
    chk_byte(rd, b, "test fifo");
    // parallel fifo mode: init high keeps the peripheral forward
    bus(1'b1, OFF_ECR, ecr(MODE_SPP, 1'b0, 1'b1));
    bus(1'b1, OFF_CTRL, 8'h04);
    bus(1'b1, OFF_ECR, ecr(MODE_PFIFO, 1'b0, 1'b1));
    b = 8'($urandom());
    bus(1'b1, OFF_DFIFO, b);
    exp_q.push_back({1'b1, b});
    drain();
    end_of_test();
  end
endmodule

//--- verilog/ecp_pkg.sv
// shared constants and types for the extended parallel port block
package ecp_pkg;
  // register byte addresses on the bus
  localparam logic [4:0] OFF_DATA = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_CTRL = 5'h08;
  localparam logic [4:0] OFF_DFIFO = 5'h0C;
  localparam logic [4:0] OFF_ECR = 5'h10;
  localparam logic [4:0] OFF_THR = 5'h14;
  // fifo geometry
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam int FIFO_AW = 4;
  // operating modes
  localparam logic [2:0] MODE_SPP = 3'h0;
  localparam logic [2:0] MODE_BIDIR = 3'h1;
  localparam logic [2:0] MODE_PFIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_TEST = 3'h6;
  // extended control field positions
  localparam int ECR_MODE_LSB = 5;
  localparam int ECR_ERRDIS = 4;
  localparam int ECR_DMA = 3;
  localparam int ECR_SVC = 2;
  // device control field positions
  localparam int CTRL_STB = 0;
  localparam int CTRL_AFD = 1;
  localparam int CTRL_INIT = 2;
  localparam int CTRL_SEL = 3;
  localparam int CTRL_DIR = 5;
  // values after reset
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic SVC_RST = 1'b1;
  localparam logic [3:0] THR_RST = 4'h8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_RO_ONES = 8'hC0;
  localparam logic [2:0] STATUS_LOW_ONES = 3'h7;
  // one fifo slot: command tag plus byte
  typedef struct packed {
    logic cmd;
    logic [7:0] data;
  } ecp_entry_s;
  // synchronised peripheral inputs
  typedef struct packed {
    logic valid_n;
    logic ack;
    logic rev_ack_n;
    logic select;
    logic err_n;
    logic [7:0] data;
  } ecp_pins_s;
  typedef enum logic [2:0] {
    LK_IDLE, LK_FWD_STB, LK_FWD_BUSY, LK_FWD_DONE, LK_REV_REQ, LK_REV_REL
  } ecp_link_e;
endpackage

//--- verilog/ecp_port.sv
// extended parallel port: fifo, dma request, service event and link handshake
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module ecp_port import ecp_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // dma channel
  output logic port_dma_request,
  input wire logic dma_ack,
  input wire logic dma_tc,
  input wire logic [7:0] dma_wdata,
  output logic [7:0] dma_rdata,
  // event line
  output logic port_irq,
  // parallel port pins
  input wire logic [7:0] port_data_lines_in,
  output logic [7:0] port_data_lines_out,
  output logic port_data_lines_oe,
  output logic host_write_pulse_n,
  output logic host_tag_line,
  output logic initialise_out_n,
  output logic select_input_out_n,
  input wire logic peripheral_valid_line_n,
  input wire logic peripheral_handshake_line,
  input wire logic turnaround_acknowledge_n,
  input wire logic peripheral_error_line_n,
  input wire logic printer_select
);

  ecp_pins_s pin_s1;
  ecp_pins_s pin;
  logic [2:0] mode;
  logic err_int_dis;
  logic dma_allow_bit;
  logic service_event_bit;
  logic [3:0] fifo_threshold;
  logic [7:0] ctrl;
  logic [7:0] data_reg;
  ecp_entry_s mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_ptr;
  logic [FIFO_AW-1:0] rd_ptr;
  logic [4:0] count;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_on;
  logic dir;
  logic auto_mode;
  logic ack_q;
  logic acc;
  logic ecr_wr;
  logic bus_push;
  logic bus_pop;
  logic dma_go;
  logic dma_push;
  logic dma_pop;
  logic link_push;
  logic link_pop;
  logic push;
  logic pop;
  ecp_entry_s push_entry;
  ecp_entry_s head;
  ecp_link_e lk_state;
  logic lk_strobe_n;
  logic lk_tag;
  logic [7:0] lk_data;
  logic svc_cond;
  logic svc_hw_set;
  logic svc_irq;
  logic err_irq;
  logic err_prev_n;
  logic err_fall;

  function automatic logic is_sw_mode(input logic [2:0] m);
    is_sw_mode = (m == MODE_SPP) || (m == MODE_BIDIR);
  endfunction

  // two flops on every pin input before use
  always_ff @(posedge sys_clk) begin
    pin_s1 <= '{peripheral_valid_line_n, peripheral_handshake_line,
      turnaround_acknowledge_n, printer_select, peripheral_error_line_n,
      port_data_lines_in};
    pin <= pin_s1;
  end

  // direction has no effect in standard and parallel fifo modes
  assign dir = ctrl[CTRL_DIR] && (mode != MODE_SPP) && (mode != MODE_PFIFO);
  assign fifo_on = (mode == MODE_PFIFO) || (mode == MODE_ECP) || (mode == MODE_TEST);
  assign auto_mode = (mode == MODE_ECP) || (mode == MODE_PFIFO);
  assign fifo_full = (count == FIFO_DEPTH);
  assign fifo_empty = (count == 5'h00);
  assign head = mem[rd_ptr];

  // bus slave: one wait cycle, action at the edge where waitrequest is low
  assign waitrequest = (read || write) && !ack_q;
  assign acc = (read || write) && ack_q;
  assign ecr_wr = acc && write && byteenable[0] && (address == OFF_ECR);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read || write) && !ack_q;
    end
  end

  // address/rle writes carry the command tag; no compression here
  assign bus_push = acc && write && byteenable[0] && fifo_on && !fifo_full &&
    (((address == OFF_DFIFO) && (!dir || mode == MODE_TEST)) ||
     ((address == OFF_DATA) && (mode == MODE_ECP) && !dir));
  assign bus_pop = acc && read && (address == OFF_DFIFO) && fifo_on &&
    !fifo_empty && (dir || mode == MODE_TEST);

  // dma: bus access wins a same-cycle collision
  assign port_dma_request = dma_allow_bit && !service_event_bit && fifo_on &&
    (dir ? !fifo_empty : !fifo_full);
  assign dma_go = dma_ack && port_dma_request;
  assign dma_push = dma_go && !dir && !bus_push;
  assign dma_pop = dma_go && dir && !bus_pop;

  assign push = bus_push || dma_push || link_push;
  assign pop = bus_pop || dma_pop || link_pop;

  always_comb begin
    push_entry = '{1'b0, dma_wdata};
    if (bus_push) begin
      push_entry = '{address == OFF_DATA, writedata[7:0]};
    end else if (link_push) begin
      // reverse commands always have msb clear
      push_entry = '{!pin.ack, pin.ack ? pin.data : {1'b0, pin.data[6:0]}};
    end
  end

  // one shared buffer for every queue; cleared whenever not in a fifo mode
  always_ff @(posedge sys_clk) begin
    if (!nrst || !fifo_on) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= 5'h00;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
      if (push && !pop) begin
        count <= count + 5'h01;
      end else if (pop && !push) begin
        count <= count - 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= push_entry;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dma_rdata <= 8'h00;
    end else if (dma_pop) begin
      dma_rdata <= head.data;
    end
  end

  // extended control register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mode <= MODE_RST;
      err_int_dis <= 1'b0;
      dma_allow_bit <= 1'b0;
    end else if (ecr_wr) begin
      // leaving a transfer mode is only allowed back to a software mode
      if (is_sw_mode(mode) || is_sw_mode(writedata[7:5])) begin
        mode <= writedata[7:5];
      end
      err_int_dis <= writedata[ECR_ERRDIS];
      dma_allow_bit <= writedata[ECR_DMA];
    end
  end

  // service conditions; thresholds share one 4-bit field
  always_comb begin
    if (dma_allow_bit) begin
      svc_cond = dma_go && dma_tc;
    end else if (!dir) begin
      svc_cond = fifo_on && ((FIFO_DEPTH - count) >= {1'b0, fifo_threshold});
    end else begin
      svc_cond = fifo_on && (count >= {1'b0, fifo_threshold});
    end
  end
  assign svc_hw_set = !service_event_bit && svc_cond;

  // hardware set beats a software clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      service_event_bit <= SVC_RST;
    end else if (svc_hw_set) begin
      service_event_bit <= 1'b1;
    end else if (ecr_wr) begin
      service_event_bit <= writedata[ECR_SVC];
    end
  end

  // error event on falling error line, forward ecp only
  assign err_fall = err_prev_n && !pin.err_n && (mode == MODE_ECP) && !dir &&
    !err_int_dis;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      err_prev_n <= 1'b1;
      svc_irq <= 1'b0;
      err_irq <= 1'b0;
    end else begin
      err_prev_n <= pin.err_n;
      // software writing the service bit itself raises nothing
      if (svc_hw_set) begin
        svc_irq <= 1'b1;
      end else if (ecr_wr) begin
        svc_irq <= 1'b0;
      end
      if (err_fall) begin
        err_irq <= 1'b1;
      end else if (ecr_wr) begin
        err_irq <= 1'b0;
      end
    end
  end
  assign port_irq = svc_irq || err_irq;

  // other software registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl <= CTRL_RST;
      data_reg <= 8'h00;
      fifo_threshold <= THR_RST;
    end else if (acc && write && byteenable[0]) begin
      if (address == OFF_CTRL) begin
        ctrl[4:0] <= writedata[4:0];
        if (mode == MODE_BIDIR) begin
          ctrl[CTRL_DIR] <= writedata[CTRL_DIR];
        end
      end
      if (address == OFF_DATA && is_sw_mode(mode)) begin
        data_reg <= writedata[7:0];
      end
      if (address == OFF_THR) begin
        fifo_threshold <= writedata[3:0];
      end
    end
  end

  // read data is registered during the wait cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      readdata <= 32'h00000000;
    end else if (read && !ack_q) begin
      case (address)
        OFF_DATA: readdata <= {24'h000000,
          (mode == MODE_BIDIR) ? pin.data : data_reg};
        OFF_STATUS: readdata <= {24'h000000, !pin.ack, pin.valid_n,
          pin.rev_ack_n, pin.select, pin.err_n, STATUS_LOW_ONES};
        OFF_CTRL: readdata <= {24'h000000, ctrl | CTRL_RO_ONES};
        OFF_DFIFO: readdata <= {24'h000000, head.data};
        OFF_ECR: readdata <= {24'h000000, mode, err_int_dis, dma_allow_bit,
          service_event_bit, fifo_full, fifo_empty};
        OFF_THR: readdata <= {28'h0000000, fifo_threshold};
        default: readdata <= 32'h00000000;
      endcase
    end
  end

  // link handshake
  assign link_pop = (lk_state == LK_IDLE) && auto_mode && !dir && !fifo_empty &&
    !pin.ack && pin.rev_ack_n;
  assign link_push = (lk_state == LK_REV_REQ) && !pin.valid_n && !fifo_full;

  always_ff @(posedge sys_clk) begin
    if (!nrst || !auto_mode) begin
      lk_state <= LK_IDLE;
      lk_strobe_n <= 1'b1;
      lk_tag <= 1'b1;
      lk_data <= 8'h00;
    end else begin
      case (lk_state)
        LK_IDLE: begin
          if (link_pop) begin
            lk_data <= head.data;
            lk_tag <= !head.cmd;
            lk_state <= LK_FWD_STB;
          end else if ((mode == MODE_ECP) && dir && !pin.rev_ack_n &&
              !fifo_full) begin
            lk_tag <= 1'b0;
            lk_state <= LK_REV_REQ;
          end
        end
        // data held a cycle before the strobe falls
        LK_FWD_STB: begin
          lk_strobe_n <= 1'b0;
          lk_state <= LK_FWD_BUSY;
        end
        LK_FWD_BUSY: begin
          if (pin.ack) begin
            lk_strobe_n <= 1'b1;
            lk_state <= LK_FWD_DONE;
          end
        end
        LK_FWD_DONE: begin
          if (!pin.ack) begin
            lk_tag <= 1'b1;
            lk_state <= LK_IDLE;
          end
        end
        LK_REV_REQ: begin
          if (link_push) begin
            lk_tag <= 1'b1;
            lk_state <= LK_REV_REL;
          end
        end
        LK_REV_REL: begin
          if (pin.valid_n) begin
            lk_state <= LK_IDLE;
          end
        end
        default: lk_state <= LK_IDLE;
      endcase
    end
  end

  // pins: software modes follow the control register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      port_data_lines_out <= 8'h00;
    end else begin
      // the popped byte reaches the pins a cycle ahead of the falling strobe
      port_data_lines_out <= !auto_mode ? data_reg : (link_pop ? head.data : lk_data);
    end
  end
  assign port_data_lines_oe = !dir && ((mode != MODE_ECP) || pin.rev_ack_n);
  assign host_write_pulse_n = auto_mode ? lk_strobe_n : !ctrl[CTRL_STB];
  assign host_tag_line = auto_mode ? lk_tag : !ctrl[CTRL_AFD];
  assign initialise_out_n = (mode == MODE_ECP) ? !dir : ctrl[CTRL_INIT];
  assign select_input_out_n = (mode == MODE_ECP) ? 1'b1 : !ctrl[CTRL_SEL];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_fwd_start;
    link_pop && (lk_state == LK_IDLE);
  endsequence
  sequence s_strobe_low;
    lk_strobe_n ##1 !lk_strobe_n;
  endsequence

  chk_dma_gate: assert property (!dma_allow_bit |-> !port_dma_request)
    else $error("dma request while dma disabled");
  chk_svc_blocks: assert property (service_event_bit |-> !port_dma_request)
    else $error("dma request while service bit set");
  chk_tc_sets: assert property (dma_allow_bit && !service_event_bit && dma_go && dma_tc
    |=> service_event_bit && port_irq)
    else $error("terminal count did not set service bit");
  chk_free_sets: assert property (!dma_allow_bit && !service_event_bit && fifo_on
    && !dir && (FIFO_DEPTH - count) >= {1'b0, fifo_threshold} |=> service_event_bit)
    else $error("free space did not set service bit");
  chk_full_flag: assert property (push && !pop && count == 5'h0F && fifo_on
    |=> fifo_full && !fifo_empty)
    else $error("full flag late");
  chk_strobe_seq: assert property (s_fwd_start |=> s_strobe_low)
    else $error("strobe did not follow fifo pop");
  chk_tag_data: assert property (s_fwd_start ##1 lk_state == LK_FWD_STB
    |-> host_tag_line == !$past(head.cmd))
    else $error("tag line does not match byte kind");
  chk_rev_take: assert property (link_push |=> host_tag_line &&
    lk_state == LK_REV_REL && !fifo_empty)
    else $error("reverse byte not taken");
  chk_drive_dir: assert property (port_data_lines_oe |-> !dir)
    else $error("data lines driven in reverse");
  chk_sel_ecp: assert property (mode == MODE_ECP |-> select_input_out_n)
    else $error("select asserted in ecp mode");
  chk_mode_lock: assert property (ecr_wr && !is_sw_mode(mode) &&
    !is_sw_mode(writedata[7:5]) |=> mode == $past(mode))
    else $error("illegal mode change accepted");
  chk_fifo_off: assert property (!fifo_on |=> fifo_empty)
    else $error("fifo holds data outside fifo modes");

endmodule
